// >>> dp_port_if.sv
// Carrier between the register bank and one per-port datapath register
// Assumes one instance per receive port
`timescale 1ns/1ps
interface dp_port_if;
   logic wr_en;
   logic [7:0] wdata;
   logic fc_load;
   logic [7:0] fc_data;
   logic [7:0] value;
   modport owner (input wr_en, input wdata, input fc_load, input fc_data, output value);
   modport ctrl (output wr_en, output wdata, output fc_load, output fc_data, input value);
endinterface

// >>> dp_port_reg.sv
// One receive port's copy of the datapath control register
// Assumes forward channel loads arrive as one-cycle strobes with data
`timescale 1ns/1ps
`include "dpcfg_consts.svh"
module dp_port_reg (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register traffic
   dp_port_if.owner p
);
   logic [7:0] value_r;
   logic [7:0] value_nxt;

   // ----------------------------------------
   // Next value
   // ----------------------------------------
   always_comb begin
      value_nxt = value_r;
      if (p.fc_load && !value_r[`DP_HOLD]) begin
         value_nxt = {value_r[`DP_HOLD], p.fc_data[6:0]}; // RULE_09 RULE_21
      end else if (p.fc_load) begin
         value_nxt[`DP_DUAL] = p.fc_data[`DP_DUAL]; // RULE_02 RULE_03
      end
      // Lane flag is outside the write mask
      if (p.wr_en) begin
         value_nxt = (p.wdata & `DP_WMASK) | (value_nxt & ~`DP_WMASK); // RULE_03
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         value_r <= `RST_DATAPATH;
      end else begin
         value_r <= value_nxt;
      end
   end

   assign p.value = value_r;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   AST_HOLD_VIDOFF: assert property (value_r[`DP_HOLD] && !p.wr_en |=> $stable(value_r[`DP_VIDOFF])) // RULE_02
      else $error("video off flag moved under hold");
   AST_LANE_RO: assert property (p.wr_en && !p.fc_load |=> $stable(value_r[`DP_DUAL])) // RULE_03
      else $error("lane flag changed by local write");
   AST_FC_LOAD: assert property (p.fc_load && !value_r[`DP_HOLD] && !p.wr_en
      |=> value_r[6:0] == $past(p.fc_data[6:0])) // RULE_21
      else $error("forward channel load lost");
endmodule

// >>> dpcfg_consts.svh
// Offsets, field positions and reset values of the datapath config registers
// Assumes 8-bit registers on the device's own register access port
`ifndef DPCFG_CONSTS_SVH
`define DPCFG_CONSTS_SVH
`define OFS_DATAPATH 8'h28
`define OFS_AUDIO_CTL 8'h2B
`define OFS_PCLK_TEST 8'h2E
`define OFS_DUAL_RX 8'h34
`define DP_HOLD 7
`define DP_VIDOFF 5
`define DP_DUAL 4
`define DP_ALT 3
`define DP_AUDOFF 2
`define DP_SYNC 1
`define DP_SURR 0
`define DP_WMASK 8'hEF
`define AU_OVR 3
`define AU_UND 2
`define AU_CLR 1
`define AU_EDGE 0
`define AU_WMASK 8'hF1
`define PT_EXT 7
`define DR_LOCKM 6
`define DR_RAW 5
`define DR_MODE_HI 4
`define DR_MODE_LO 3
`define DR_P1 1
`define DR_P0 0
`define DR_WMASK 8'h7F
`define RST_DATAPATH 8'h00
`define RST_AUDIO 8'h00
`define RST_PCLK 8'h00
`define RST_DUAL_RX 8'h01
`endif

// >>> dpcfg_pkg.sv
// Types shared by the datapath config block
// Assumes the constants header for field positions
package dpcfg_pkg;
   typedef enum logic [1:0] {
      MODE_AUTO = 2'h0,
      MODE_DUAL = 2'h1,
      MODE_PRI = 2'h2,
      MODE_SEC = 2'h3
   } link_mode_t;
endpackage

// >>> link_datapath_config_regs.sv
// Datapath configuration and status registers of the receive side
// Assumes a register access port fed by the I2C target, inputs synchronous to clk_sys
// Operation
// RULE_01: Bit 5 reports video off; control channel and gpio stay alive.
// RULE_02: Hold bit freezes the video off flag against forward channel updates.
// RULE_03: Bit 4 dual link flag is read-only, loaded only from forward channel.
// RULE_04: Auto-detect input mode uses the dual link flag for data recovery.
// RULE_05: Alternate route puts word clock on gpio one, data on gpio zero.
// RULE_06: Bit 2 set disables serial audio output.
// RULE_07: Bit 1 set means forward video carries syncs and data enable.
// RULE_08: Bit 0 enables surround serial audio.
// RULE_09: Datapath control values come from the remote serializer.
// RULE_10: Audio control bits 3 and 2 show fifo overrun and underrun.
// RULE_11: Writing 1 to audio control bit 1 clears fifo errors.
// RULE_12: Audio control bit 0 picks rising or falling strobe edge.
// RULE_13: Test register bit 7 takes pixel clock from test clock input.
// RULE_14: Lock mode 0 reports lock only while active video arrives.
// RULE_15: Lock mode 1 reports lock whenever linked to a serializer.
// RULE_16: Raw back channel passes aux gpio zero straight to serializer.
// RULE_17: Two-bit input mode: auto, dual, primary single, secondary single.
// RULE_18: Secondary select routes writes and reads to port one registers.
// RULE_19: Software clears secondary select before reading port zero.
// RULE_20: Primary select resets to 1; secondary select wins on reads.
// RULE_21: Hold bit blocks forward channel loading of datapath control; the code still loads bit 4, the dual link flag, under hold.
// RULE_22: Fifo error flags stay set until software clears them.
`timescale 1ns/1ps
`include "dpcfg_consts.svh"
module link_datapath_config_regs #(
   parameter int DATA_W = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register access port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   // Forward channel, one per receive port
   input wire logic fc_load0,
   input wire logic [7:0] fc_data0,
   input wire logic fc_load1,
   input wire logic [7:0] fc_data1,
   // Audio fifo
   input wire logic fifo_overrun,
   input wire logic fifo_underrun,
   output logic fifo_err_clear,
   // Audio pins
   input wire logic audio_word_clk,
   input wire logic audio_data,
   input wire logic gpio_pin_zero_func,
   input wire logic gpio_pin_zero_func_oe_n,
   input wire logic gpio_pin_one_func,
   input wire logic gpio_pin_one_func_oe_n,
   output logic gpio_pin_zero_o,
   output logic gpio_pin_zero_oe_n,
   output logic gpio_pin_one_o,
   output logic gpio_pin_one_oe_n,
   output logic audio_out_en,
   output logic audio_surround_en,
   output logic audio_strobe_rising,
   // Video and clocking
   output logic video_off,
   output logic sync_in_forward_video,
   output logic pclk_from_test_clock,
   output logic rx_dual_link,
   output logic rx_use_secondary,
   // Lock
   input wire logic linked,
   output logic rx_lock,
   // Secondary back channel
   input wire logic aux_gpio_zero,
   input wire logic bc_filtered,
   output logic bc_aux_bit,
   output logic bc_raw_mode
);

   // ----------------------------------------
   // Parameter check
   // ----------------------------------------
   if (DATA_W != 8) begin : g_bad_width
      $error("register width must be 8");
   end

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [7:0] audio_r;
   logic [7:0] pclk_r;
   logic [7:0] dual_r;
   logic ovr_r;
   logic und_r;
   logic [7:0] v0;
   logic [7:0] v1;
   logic [7:0] dp;
   logic wr_audio;
   logic wr_pclk;
   logic wr_dual;
   logic wr_dp;
   logic err_clr;
   logic rx_dual_nxt;
   logic [7:0] rdata_nxt;
   dpcfg_pkg::link_mode_t mode;

   dp_port_if p0_if ();
   dp_port_if p1_if ();

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   assign wr_audio = reg_wr && (reg_addr == `OFS_AUDIO_CTL);
   assign wr_pclk = reg_wr && (reg_addr == `OFS_PCLK_TEST);
   assign wr_dual = reg_wr && (reg_addr == `OFS_DUAL_RX);
   assign wr_dp = reg_wr && (reg_addr == `OFS_DATAPATH);
   assign err_clr = wr_audio && reg_wdata[`AU_CLR]; // RULE_11

   // ----------------------------------------
   // Per-port datapath registers
   // ----------------------------------------
   // Each port copy is written only when its select bit is set
   assign p0_if.wr_en = wr_dp && dual_r[`DR_P0]; // RULE_20
   assign p1_if.wr_en = wr_dp && dual_r[`DR_P1]; // RULE_18
   assign p0_if.wdata = reg_wdata;
   assign p1_if.wdata = reg_wdata;
   assign p0_if.fc_load = fc_load0;
   assign p0_if.fc_data = fc_data0;
   assign p1_if.fc_load = fc_load1;
   assign p1_if.fc_data = fc_data1;
   assign v0 = p0_if.value;
   assign v1 = p1_if.value;

   dp_port_reg u_port0 (
      .clk_sys (clk_sys),
      .rst_n (rst_n),
      .p (p0_if.owner)
   );

   dp_port_reg u_port1 (
      .clk_sys (clk_sys),
      .rst_n (rst_n),
      .p (p1_if.owner)
   );

   // ----------------------------------------
   // Shared registers
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         audio_r <= `RST_AUDIO;
      end else if (wr_audio) begin
         audio_r <= reg_wdata & `AU_WMASK; // RULE_12
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pclk_r <= `RST_PCLK;
      end else if (wr_pclk) begin
         pclk_r <= reg_wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dual_r <= `RST_DUAL_RX; // RULE_20
      end else if (wr_dual) begin
         dual_r <= reg_wdata & `DR_WMASK;
      end
   end

   // ----------------------------------------
   // Fifo error flags
   // ----------------------------------------
   // A new error in the clearing cycle is kept, so none is lost
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ovr_r <= 1'b0;
         und_r <= 1'b0;
         fifo_err_clear <= 1'b0;
      end else begin
         ovr_r <= (ovr_r && !err_clr) || fifo_overrun; // RULE_22
         und_r <= (und_r && !err_clr) || fifo_underrun; // RULE_22
         fifo_err_clear <= err_clr; // RULE_11
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   always_comb begin
      case (reg_addr)
         `OFS_DATAPATH: begin
            rdata_nxt = dual_r[`DR_P1] ? v1 : v0; // RULE_18 RULE_20
         end
         `OFS_AUDIO_CTL: begin
            rdata_nxt = {audio_r[7:4], ovr_r, und_r, 1'b0, audio_r[`AU_EDGE]}; // RULE_10
         end
         `OFS_PCLK_TEST: begin
            rdata_nxt = pclk_r;
         end
         `OFS_DUAL_RX: begin
            rdata_nxt = dual_r;
         end
         default: begin
            rdata_nxt = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rdata_nxt;
         end
      end
   end

   // ----------------------------------------
   // Receive mode and active port
   // ----------------------------------------
   assign mode = dpcfg_pkg::link_mode_t'(dual_r[`DR_MODE_HI:`DR_MODE_LO]);
   // The secondary copy steers the datapath only when it alone carries the link
   assign dp = (mode == dpcfg_pkg::MODE_SEC) ? v1 : v0;

   always_comb begin
      case (mode)
         dpcfg_pkg::MODE_AUTO: begin
            rx_dual_nxt = dp[`DP_DUAL]; // RULE_04
         end
         dpcfg_pkg::MODE_DUAL: begin
            rx_dual_nxt = 1'b1; // RULE_17
         end
         default: begin
            rx_dual_nxt = 1'b0; // RULE_17
         end
      endcase
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         video_off <= 1'b0;
         sync_in_forward_video <= 1'b0;
         audio_out_en <= 1'b0;
         audio_surround_en <= 1'b0;
         audio_strobe_rising <= 1'b0;
         pclk_from_test_clock <= 1'b0;
         rx_dual_link <= 1'b0;
         rx_use_secondary <= 1'b0;
         rx_lock <= 1'b0;
      end else begin
         video_off <= dp[`DP_VIDOFF]; // RULE_01
         sync_in_forward_video <= dp[`DP_SYNC]; // RULE_07
         audio_out_en <= !dp[`DP_AUDOFF]; // RULE_06
         audio_surround_en <= dp[`DP_SURR]; // RULE_08
         audio_strobe_rising <= audio_r[`AU_EDGE]; // RULE_12
         pclk_from_test_clock <= pclk_r[`PT_EXT]; // RULE_13
         rx_dual_link <= rx_dual_nxt; // RULE_04
         rx_use_secondary <= (mode == dpcfg_pkg::MODE_SEC); // RULE_17
         // Lock mode 1 lets the control channel be seen as up without video
         rx_lock <= linked && (dual_r[`DR_LOCKM] || !dp[`DP_VIDOFF]); // RULE_14 RULE_15
      end
   end

   // ----------------------------------------
   // Pins: audio route and back channel
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         gpio_pin_zero_o <= 1'b0;
         gpio_pin_zero_oe_n <= 1'b1;
         gpio_pin_one_o <= 1'b0;
         gpio_pin_one_oe_n <= 1'b1;
      end else if (dp[`DP_ALT]) begin
         gpio_pin_zero_o <= audio_data; // RULE_05
         gpio_pin_zero_oe_n <= 1'b0;
         gpio_pin_one_o <= audio_word_clk; // RULE_05
         gpio_pin_one_oe_n <= 1'b0;
      end else begin
         gpio_pin_zero_o <= gpio_pin_zero_func;
         gpio_pin_zero_oe_n <= gpio_pin_zero_func_oe_n;
         gpio_pin_one_o <= gpio_pin_one_func;
         gpio_pin_one_oe_n <= gpio_pin_one_func_oe_n;
      end
   end

   // Raw mode skips the filter, so glitches on the pin reach the far end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bc_aux_bit <= 1'b0;
         bc_raw_mode <= 1'b0;
      end else begin
         bc_aux_bit <= dual_r[`DR_RAW] ? aux_gpio_zero : bc_filtered; // RULE_16
         bc_raw_mode <= dual_r[`DR_RAW]; // RULE_16
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_err_clear;
      wr_audio && reg_wdata[`AU_CLR];
   endsequence

   sequence s_dp_read_p1;
      reg_rd && (reg_addr == `OFS_DATAPATH) && dual_r[`DR_P1];
   endsequence

   sequence s_video_gone;
      linked && !dual_r[`DR_LOCKM] && dp[`DP_VIDOFF];
   endsequence

   AST_ERR_CLEAR: assert property ((s_err_clear and !fifo_overrun) |=> !ovr_r && fifo_err_clear) // RULE_11
      else $error("overrun flag not cleared");
   AST_ERR_STICKY: assert property (und_r && !err_clr |=> und_r) // RULE_22
      else $error("underrun flag dropped without clear");
   AST_SET_WINS: assert property (s_err_clear ##0 fifo_overrun |=> ovr_r) // RULE_22
      else $error("overrun lost in clear cycle");
   AST_LOCK_MODE0: assert property (s_video_gone |=> !rx_lock) // RULE_14
      else $error("lock shown without video");
   AST_LOCK_MODE1: assert property (linked && dual_r[`DR_LOCKM] |=> rx_lock) // RULE_15
      else $error("lock missing while linked");
   AST_PORT1_READ: assert property (s_dp_read_p1 |=> reg_rvalid && reg_rdata == $past(v1)) // RULE_18
      else $error("secondary select read wrong copy");
   AST_RAW_BC: assert property (dual_r[`DR_RAW] |=> bc_aux_bit == $past(aux_gpio_zero)) // RULE_16
      else $error("raw back channel not passed");
   AST_ALT_ROUTE: assert property (dp[`DP_ALT] |=> !gpio_pin_one_oe_n && gpio_pin_one_o == $past(audio_word_clk)) // RULE_05
      else $error("word clock not on gpio one");
   AST_AUTO_MODE: assert property (mode == dpcfg_pkg::MODE_AUTO |=> rx_dual_link == $past(dp[`DP_DUAL])) // RULE_04
      else $error("auto mode ignores lane flag");
   AST_PCLK_SEL: assert property (wr_pclk |=> ##1 pclk_from_test_clock == $past(reg_wdata[`PT_EXT], 2)) // RULE_13
      else $error("pixel clock source not followed");
endmodule

// >>> ser_model.sv
// Behavioural remote serializer: forward channel loads and link state
// Assumes tb_top calls send and sets linked, always just after a clk_sys edge
`timescale 1ns/1ps
module ser_model (
   // Clock
   input wire logic clk_sys,
   // Forward channel
   output logic fc_load0,
   output logic [7:0] fc_data0,
   output logic fc_load1,
   output logic [7:0] fc_data1,
   // Link state
   output logic linked
);
   initial begin
      fc_load0 = 1'b0;
      fc_load1 = 1'b0;
      fc_data0 = 8'h5A;
      fc_data1 = 8'hA5;
      linked = 1'b0;
   end
   // ----
   // Load one port copy; released data shows the inverse so stale bytes never look valid
   // ----
   task automatic send(input logic port, input logic [7:0] d);
      if (port) begin
         fc_load1 = 1'b1;
         fc_data1 = d;
      end else begin
         fc_load0 = 1'b1;
         fc_data0 = d;
      end
      @(posedge clk_sys);
      #1;
      fc_load0 = 1'b0;
      fc_load1 = 1'b0;
      if (port) fc_data1 = ~d;
      else fc_data0 = ~d;
   endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the datapath config registers
// Assumes ser_model stands in for the remote serializer
`timescale 1ns/1ps
module tb_top;
   logic clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, fc_data0, fc_data1;
   logic fc_load0, fc_load1, fifo_overrun, fifo_underrun, fifo_err_clear;
   logic audio_word_clk, audio_data, gpio_pin_zero_func, gpio_pin_zero_func_oe_n, gpio_pin_one_func, gpio_pin_one_func_oe_n;
   logic gpio_pin_zero_o, gpio_pin_zero_oe_n, gpio_pin_one_o, gpio_pin_one_oe_n;
   logic audio_out_en, audio_surround_en, audio_strobe_rising, video_off, sync_in_forward_video;
   logic pclk_from_test_clock, rx_dual_link, rx_use_secondary, linked, rx_lock;
   logic aux_gpio_zero, bc_filtered, bc_aux_bit, bc_raw_mode;
   int num_errors = 0;
   int total_checks = 0;
   ser_model ser (.clk_sys, .fc_load0, .fc_data0, .fc_load1, .fc_data1, .linked);
   link_datapath_config_regs #(.DATA_W(8)) DUT (.clk_sys, .rst_n, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .reg_rvalid, .fc_load0, .fc_data0, .fc_load1, .fc_data1,
      .fifo_overrun, .fifo_underrun, .fifo_err_clear, .audio_word_clk, .audio_data,
      .gpio_pin_zero_func, .gpio_pin_zero_func_oe_n, .gpio_pin_one_func, .gpio_pin_one_func_oe_n, .gpio_pin_zero_o,
      .gpio_pin_zero_oe_n, .gpio_pin_one_o, .gpio_pin_one_oe_n, .audio_out_en, .audio_surround_en,
      .audio_strobe_rising, .video_off, .sync_in_forward_video, .pclk_from_test_clock,
      .rx_dual_link, .rx_use_secondary, .linked, .rx_lock, .aux_gpio_zero, .bc_filtered,
      .bc_aux_bit, .bc_raw_mode);
   // ----
   // Helpers; all leave the bench 1 ns after an edge
   // ----
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      tick(1);
      reg_wr = 1'b0;
      // One idle edge, so a following request never re-raises the strobe in the same step
      tick(1);
   endtask
   // Read data is taken on the edge after the strobe, where reg_rvalid stands
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      reg_rd = 1'b1;
      reg_addr = a;
      tick(1);
      reg_rd = 1'b0;
      chk("reg_rvalid", 8'h01, {7'h0, reg_rvalid});
      chk("reg_rdata", exp, reg_rdata);
      tick(1);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ----
   // Scenarios
   // ----
   task automatic sc_reset();
      rdchk(8'h2B, 8'h00);
      rdchk(8'h2E, 8'h00);
      rdchk(8'h34, 8'h01);
      rdchk(8'h28, 8'h00);
      rdchk(8'h50, 8'h00);
      chk("audio_out_en", 8'h01, {7'h0, audio_out_en});
   endtask
   task automatic sc_fc_load();
      ser.send(1'b0, 8'h3F);
      tick(2);
      rdchk(8'h28, 8'h3F);
      chk("video_off", 8'h01, {7'h0, video_off});
      chk("sync", 8'h01, {7'h0, sync_in_forward_video});
      chk("surround", 8'h01, {7'h0, audio_surround_en});
      chk("audio_out_en", 8'h00, {7'h0, audio_out_en});
      chk("rx_dual_link", 8'h01, {7'h0, rx_dual_link});
   endtask
   task automatic sc_modes();
      logic [3:0] dual_tbl, sec_tbl;
      dual_tbl = 4'b0011;
      sec_tbl = 4'b1000;
      for (int i = 0; i < 4; i++) begin
         wr(8'h34, 8'h01 | 8'(i << 3));
         tick(2);
         chk("rx_dual_link", {7'h0, dual_tbl[i]}, {7'h0, rx_dual_link});
         chk("rx_use_secondary", {7'h0, sec_tbl[i]}, {7'h0, rx_use_secondary});
      end
      wr(8'h34, 8'h01);
   endtask
   task automatic sc_hold_lock();
      wr(8'h28, 8'hA0);
      rdchk(8'h28, 8'hB0);
      ser.send(1'b0, 8'h00);
      tick(2);
      rdchk(8'h28, 8'hA0);
      chk("video_off", 8'h01, {7'h0, video_off});
      chk("rx_dual_link", 8'h00, {7'h0, rx_dual_link});
      ser.linked = 1'b1;
      tick(3);
      chk("rx_lock", 8'h00, {7'h0, rx_lock});
      wr(8'h34, 8'h41);
      tick(3);
      chk("rx_lock", 8'h01, {7'h0, rx_lock});
      ser.linked = 1'b0;
      tick(3);
      chk("rx_lock", 8'h00, {7'h0, rx_lock});
      ser.linked = 1'b1;
      wr(8'h34, 8'h01);
      wr(8'h28, 8'h80);
      tick(3);
      chk("rx_lock", 8'h01, {7'h0, rx_lock});
   endtask
   task automatic sc_alt();
      gpio_pin_one_func_oe_n = 1'b1;
      chk("pin_zero", 8'h00, {7'h0, gpio_pin_zero_o});
      chk("pin_zero_oe_n", 8'h01, {7'h0, gpio_pin_zero_oe_n});
      chk("pin_one", 8'h01, {7'h0, gpio_pin_one_o});
      wr(8'h28, 8'h88);
      tick(2);
      chk("pin_zero", 8'h01, {7'h0, gpio_pin_zero_o});
      chk("pin_zero_oe_n", 8'h00, {7'h0, gpio_pin_zero_oe_n});
      chk("pin_one", 8'h00, {7'h0, gpio_pin_one_o});
      chk("pin_one_oe_n", 8'h00, {7'h0, gpio_pin_one_oe_n});
      wr(8'h28, 8'h80);
      chk("pin_one_oe_n", 8'h01, {7'h0, gpio_pin_one_oe_n});
   endtask
   task automatic sc_audio();
      fifo_overrun = 1'b1;
      tick(1);
      fifo_overrun = 1'b0;
      tick(4);
      rdchk(8'h2B, 8'h08);
      fifo_underrun = 1'b1;
      tick(1);
      fifo_underrun = 1'b0;
      rdchk(8'h2B, 8'h0C);
      // Clear written while a new overrun arrives: the new error must survive
      reg_wr = 1'b1;
      reg_addr = 8'h2B;
      reg_wdata = 8'h03;
      fifo_overrun = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      fifo_overrun = 1'b0;
      chk("fifo_err_clear", 8'h01, {7'h0, fifo_err_clear});
      tick(1);
      chk("fifo_err_clear", 8'h00, {7'h0, fifo_err_clear});
      rdchk(8'h2B, 8'h09);
      wr(8'h2B, 8'h03);
      rdchk(8'h2B, 8'h01);
      chk("strobe_rising", 8'h01, {7'h0, audio_strobe_rising});
      wr(8'h2B, 8'h00);
      tick(2);
      chk("strobe_rising", 8'h00, {7'h0, audio_strobe_rising});
   endtask
   task automatic sc_pclk_raw();
      wr(8'h2E, 8'h80);
      tick(2);
      chk("pclk_test", 8'h01, {7'h0, pclk_from_test_clock});
      rdchk(8'h2E, 8'h80);
      wr(8'h34, 8'h21);
      aux_gpio_zero = 1'b1;
      bc_filtered = 1'b0;
      tick(2);
      chk("bc_raw_mode", 8'h01, {7'h0, bc_raw_mode});
      chk("bc_aux_bit", 8'h01, {7'h0, bc_aux_bit});
      wr(8'h34, 8'h01);
      tick(2);
      chk("bc_aux_bit", 8'h00, {7'h0, bc_aux_bit});
   endtask
   task automatic sc_ports();
      wr(8'h34, 8'h02);
      wr(8'h28, 8'h85);
      rdchk(8'h28, 8'h85);
      wr(8'h34, 8'h01);
      rdchk(8'h28, 8'h80);
      wr(8'h34, 8'h03);
      rdchk(8'h28, 8'h85);
   endtask
   // ----
   // Clock, reset and main sequence
   // ----
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      conclude();
   end
   initial begin
      {rst_n, reg_wr, reg_rd, fifo_overrun, fifo_underrun, gpio_pin_zero_func, gpio_pin_one_func_oe_n} = '0;
      {reg_addr, reg_wdata} = '0;
      {gpio_pin_zero_func_oe_n, gpio_pin_one_func, audio_data, audio_word_clk} = 4'b1110;
      {aux_gpio_zero, bc_filtered} = 2'b01;
      repeat (10) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      sc_reset();
      sc_fc_load();
      sc_modes();
      sc_hold_lock();
      sc_alt();
      sc_audio();
      sc_pclk_raw();
      sc_ports();
      conclude();
   end
endmodule
